// ### vsc_consts.vh
// Constants for the scroll and character video control block
`ifndef VSC_CONSTS_VH
`define VSC_CONSTS_VH

// ****************************************
// APB register byte addresses
// ****************************************
`define ADDR_CMD 12'h00C
`define ADDR_STATUS 12'h010
`define ADDR_MODE 12'h014
`define ADDR_W 12

// ****************************************
// Command codes
// ****************************************
`define CMD_TOGGLE_BLINK 4'h8
`define CMD_CLR_VIRQ 4'h9
`define CMD_REV_ON 4'hA
`define CMD_REV_OFF 4'hB
`define CMD_ATTR_24 4'hD
`define CMD_ATTR_48 4'hF

// ****************************************
// Scan rows and character codes
// ****************************************
`define SCAN_FIRST_ADDR 4'hF
`define SCAN_UNDERLINE 4'h7
`define ROW_LAST 4'h9
`define ROW_ZERO 4'h0
`define ROW_ONE 4'h1
`define CHAR_TERM 8'hFF

// ****************************************
// Column limits and gaps
// ****************************************
`define COLS_80_SINGLE 8'h53
`define COLS_80_DOUBLE 8'h29
`define COLS_132_SINGLE 8'h89
`define COLS_132_DOUBLE 8'h44
`define GAP_80 4'h2
`define GAP_132 4'h1
`define DOTS_PER_BYTE 4'h8

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 200
`define HOLDOFF_US 500
`define HOLDOFF_CYCLES (`HOLDOFF_US * `CLK_MHZ)

// ****************************************
// Mode register fields
// ****************************************
`define MODE_COL132_BIT 0
`define MODE_DOUBLE_BIT 1
`define MODE_HZ60_BIT 2

`endif

// ### video_scroll_char_control.v
// Scroll latch, command decode, scan row sequencing and dot serializer
// How it works
// - Commands arrive only as 4-bit writes to port 0CH; no read-back.
// - Codes 0..3 set the two low scroll latch bits.
// - Codes 4..7 set the two high scroll latch bits.
// - Code 9 clears the vertical interrupt raised at each vertical blank.
// - Code A turns whole-screen reverse on, code B turns it off.
// - Code 8 toggles blink; code D selects reverse, 24 lines, blink off.
// - Code F selects reverse, 48 lines, blink off.
// - Latch picks first scan row of region start and last row of region end.
// - Latch 0 gives rows 0..9; latch N starts at N, ends at N-1.
// - Line scroll flag comes from previous pointer; location 0 never scrolls.
// - 60 Hz frame starts with two blank lines chained from location 0.
// - Location 0 fetched at interrupt; second line held off 500 us.
// - Commanded latch moves into use at vertical reset of each frame.
// - ROM address is character code above 4-bit scan address.
// - Codes 00..FE are glyphs; FF flags end of line.
// - Cell scans F then 0..8; with the latch 0..9, 9..E show only on a line that both starts and ends a region; 7 is underline.
// - Bit 0 is rightmost dot and fills 2-dot or 1-dot gap.
// - Column limits 83/41 at 80 columns, 137/68 at 132 columns.
`timescale 1ns/1ps
`include "vsc_consts.vh"

module video_scroll_char_control #(
  parameter HOLDOFF_CYCLES = `HOLDOFF_CYCLES
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rstn_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Frame and line timing from the timing generator
  input wire vert_reset_in,
  input wire vblank_start_in,
  input wire line_start_in,
  input wire line_loc0_in,
  input wire line_scroll_in,
  input wire region_last_in,
  input wire scan_adv_in,
  // Character fetch and ROM
  input wire char_valid_in,
  input wire [7:0] char_code_in,
  input wire [7:0] rom_data_in,
  // Outputs to the display path
  output reg char_ready_out,
  output reg [11:0] rom_addr_out,
  output reg term_out,
  output reg col_overflow_out,
  output reg dot_out,
  output reg dot_valid_out,
  output reg underline_scan_out,
  output reg [3:0] scan_addr_out,
  output reg line_done_out,
  output reg vert_irq_out,
  output reg fetch2_hold_out,
  output reg blink_out,
  output reg reverse_field_out,
  output reg basic_rev_out,
  output reg lines48_out
);

  // ****************************************
  // APB decode
  // ****************************************
  wire access_w;
  wire cmd_wr;
  wire mode_wr;
  wire [3:0] cmd_w;
  reg [3:0] latch_q;
  reg [3:0] active_q;
  reg [2:0] mode_q;
  reg holdoff_run_q;
  reg [31:0] holdoff_cnt_q;

  assign access_w = psel_in & penable_in & ~pready_out;
  assign cmd_wr = access_w & pwrite_in & (paddr_in == `ADDR_CMD);
  assign mode_wr = access_w & pwrite_in & (paddr_in == `ADDR_MODE);
  assign cmd_w = pwdata_in[3:0];

  // One wait state: pready rises one cycle after the access phase opens
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= access_w;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
      if (access_w) begin
        case (paddr_in)
          `ADDR_CMD: begin
            // Write-only port, reads return zero
            prdata_out <= 32'h00000000;
          end
          `ADDR_STATUS: begin
            prdata_out <= {18'h00000, fetch2_hold_out, lines48_out, basic_rev_out, vert_irq_out,
              reverse_field_out, blink_out, active_q, latch_q};
          end
          `ADDR_MODE: begin
            prdata_out <= {29'h00000000, mode_q};
          end
          default: begin
            pslverr_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      latch_q <= 4'h0;
      blink_out <= 1'b0;
      reverse_field_out <= 1'b0;
      basic_rev_out <= 1'b0;
      lines48_out <= 1'b0;
      mode_q <= 3'h0;
    end else begin
      if (mode_wr) begin
        mode_q <= pwdata_in[2:0];
      end
      if (cmd_wr) begin
        if (cmd_w[3] == 1'b0) begin
          if (cmd_w[2] == 1'b0) begin
            latch_q[1:0] <= cmd_w[1:0];
          end else begin
            latch_q[3:2] <= cmd_w[1:0];
          end
        end else begin
          case (cmd_w)
            `CMD_TOGGLE_BLINK: begin
              blink_out <= ~blink_out;
            end
            `CMD_REV_ON: begin
              reverse_field_out <= 1'b1;
            end
            `CMD_REV_OFF: begin
              reverse_field_out <= 1'b0;
            end
            `CMD_ATTR_24: begin
              basic_rev_out <= 1'b1;
              lines48_out <= 1'b0;
              blink_out <= 1'b0;
            end
            `CMD_ATTR_48: begin
              basic_rev_out <= 1'b1;
              lines48_out <= 1'b1;
              blink_out <= 1'b0;
            end
            default: begin
              // Codes C and E, and 9 which is handled below, leave this state alone
              blink_out <= blink_out;
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // Vertical interrupt and second-line hold-off
  // ****************************************
  // A blank start in the same cycle as a clear keeps the interrupt set
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vert_irq_out <= 1'b0;
      holdoff_run_q <= 1'b0;
      holdoff_cnt_q <= 32'h00000000;
      fetch2_hold_out <= 1'b0;
    end else begin
      if (vblank_start_in) begin
        vert_irq_out <= 1'b1;
      end else if (cmd_wr && cmd_w == `CMD_CLR_VIRQ) begin
        vert_irq_out <= 1'b0;
      end
      // Line 0 is already in hand; the next fetch waits out the hold-off
      if (vblank_start_in) begin
        holdoff_run_q <= 1'b1;
        holdoff_cnt_q <= 32'h00000000;
        fetch2_hold_out <= 1'b1;
      end else if (holdoff_run_q) begin
        if (holdoff_cnt_q >= HOLDOFF_CYCLES - 1) begin
          holdoff_run_q <= 1'b0;
          fetch2_hold_out <= 1'b0;
        end else begin
          holdoff_cnt_q <= holdoff_cnt_q + 32'h00000001;
        end
      end
    end
  end

  // ****************************************
  // Frame latch transfer and scan row sequencing
  // ****************************************
  // Row index 0..9 maps to scan address F,0..8
  reg [3:0] row_q;
  reg [3:0] end_row_q;
  reg line_act_q;
  // Scroll attribute of the previous line, to find the top line of a region
  reg prev_scroll_q;
  wire [3:0] first_row_w;
  wire [3:0] last_row_w;
  wire line_scrolls_w;

  // Location 0 heads the blank lead-in chain, so it never scrolls
  assign line_scrolls_w = line_scroll_in & ~line_loc0_in;
  // Only the top line of a region starts late; lines inside it show all rows
  assign first_row_w = (line_scrolls_w && !prev_scroll_q) ? active_q : `ROW_ZERO;
  assign last_row_w = (active_q == `ROW_ZERO) ? `ROW_LAST : active_q - `ROW_ONE;

  function [3:0] row_to_addr;
    input [3:0] row;
    begin
      row_to_addr = (row == `ROW_ZERO) ? `SCAN_FIRST_ADDR : row - `ROW_ONE;
    end
  endfunction

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      active_q <= 4'h0;
      row_q <= 4'h0;
      end_row_q <= 4'h0;
      line_act_q <= 1'b0;
      prev_scroll_q <= 1'b0;
      line_done_out <= 1'b0;
      scan_addr_out <= `SCAN_FIRST_ADDR;
      underline_scan_out <= 1'b0;
    end else begin
      line_done_out <= 1'b0;
      if (vert_reset_in) begin
        active_q <= latch_q;
      end
      if (line_start_in) begin
        // A region's top line starts late, its bottom line ends early
        row_q <= first_row_w;
        end_row_q <= (line_scrolls_w && region_last_in) ? last_row_w : `ROW_LAST;
        line_act_q <= 1'b1;
        prev_scroll_q <= line_scrolls_w;
        scan_addr_out <= row_to_addr(first_row_w);
        underline_scan_out <= (row_to_addr(first_row_w) == `SCAN_UNDERLINE);
      end else if (scan_adv_in && line_act_q) begin
        if (row_q == end_row_q) begin
          line_act_q <= 1'b0;
          line_done_out <= 1'b1;
        end else begin
          row_q <= row_q + `ROW_ONE;
          scan_addr_out <= row_to_addr(row_q + `ROW_ONE);
          underline_scan_out <= (row_to_addr(row_q + `ROW_ONE) == `SCAN_UNDERLINE);
        end
      end
    end
  end

  // ****************************************
  // Character accept, ROM address and dot serializer
  // ****************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_ROM = 3'b010;
  localparam ST_SHIFT = 3'b100;

  reg [2:0] state_q;
  reg [7:0] shift_q;
  reg [3:0] dot_cnt_q;
  reg fill_q;
  reg [7:0] col_q;
  wire [7:0] col_limit_w;
  wire [3:0] cell_dots_w;
  wire accept_w;

  assign col_limit_w = mode_q[`MODE_COL132_BIT] ?
    (mode_q[`MODE_DOUBLE_BIT] ? `COLS_132_DOUBLE : `COLS_132_SINGLE) :
    (mode_q[`MODE_DOUBLE_BIT] ? `COLS_80_DOUBLE : `COLS_80_SINGLE);
  assign cell_dots_w = `DOTS_PER_BYTE + (mode_q[`MODE_COL132_BIT] ? `GAP_132 : `GAP_80);
  assign accept_w = char_valid_in & char_ready_out;

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      char_ready_out <= 1'b1;
      rom_addr_out <= 12'h000;
      term_out <= 1'b0;
      col_overflow_out <= 1'b0;
      shift_q <= 8'h00;
      dot_cnt_q <= 4'h0;
      fill_q <= 1'b0;
      col_q <= 8'h00;
      dot_out <= 1'b0;
      dot_valid_out <= 1'b0;
    end else begin
      term_out <= 1'b0;
      dot_valid_out <= 1'b0;
      if (line_start_in) begin
        col_q <= 8'h00;
        col_overflow_out <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (accept_w) begin
            if (char_code_in == `CHAR_TERM) begin
              term_out <= 1'b1;
            end else if (col_q >= col_limit_w) begin
              col_overflow_out <= 1'b1;
            end else begin
              rom_addr_out <= {char_code_in, scan_addr_out};
              col_q <= col_q + 8'h01;
              char_ready_out <= 1'b0;
              state_q <= ST_ROM;
            end
          end
        end
        ST_ROM: begin
          shift_q <= rom_data_in;
          fill_q <= rom_data_in[0];
          dot_cnt_q <= 4'h0;
          state_q <= ST_SHIFT;
        end
        ST_SHIFT: begin
          dot_valid_out <= 1'b1;
          // Bit 0 keeps filling the gap so joined glyphs stay joined
          if (dot_cnt_q < `DOTS_PER_BYTE) begin
            dot_out <= shift_q[7] ^ reverse_field_out;
            shift_q <= {shift_q[6:0], 1'b0};
          end else begin
            dot_out <= fill_q ^ reverse_field_out;
          end
          if (dot_cnt_q == cell_dots_w - 4'h1) begin
            char_ready_out <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            dot_cnt_q <= dot_cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          char_ready_out <= 1'b1;
        end
      endcase
    end
  end

endmodule // video_scroll_char_control

// ### char_rom_model.sv
// Character generator ROM model seen by the block's ROM address port
`timescale 1ns/1ps
module char_rom_model (
  input wire [11:0] addr_in,
  output wire [7:0] data_out
);
  // Pattern mixes code and scan, so a swapped or shifted address half shows
  assign data_out = addr_in[11:4] ^ {addr_in[3:0], ~addr_in[3:0]};
endmodule // char_rom_model

// ### video_scroll_char_control_assertions.sv
// Port checker for the scroll and character control block
`timescale 1ns/1ps
module vsc_check #(
  parameter HOLDOFF_CYCLES = 20
) (
  input wire clk_sys_in, rstn_in,
  input wire psel_in, penable_in, pwrite_in, pready_out,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire vblank_start_in, vert_irq_out, fetch2_hold_out,
  input wire blink_out, reverse_field_out, basic_rev_out, lines48_out,
  input wire char_valid_in, char_ready_out, term_out, underline_scan_out,
  input wire [7:0] char_code_in,
  input wire [11:0] rom_addr_out,
  input wire [3:0] scan_addr_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire [3:0] c = pwdata_in[3:0];
  wire wr = psel_in && penable_in && !pready_out && pwrite_in && paddr_in == 12'h00C;
  wire take = char_valid_in && char_ready_out;
  pready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready not after one wait state");
  rev_cmd_a: assert property (wr && c[3:1] == 3'h5 |=> reverse_field_out == !$past(c[0]))
    else $error("reverse field wrong after command");
  blink_tog_a: assert property (wr && c == 4'h8 |=> blink_out != $past(blink_out))
    else $error("blink did not toggle");
  attr_set_a: assert property (wr && c[3:2] == 2'h3 && c[0] |=>
    basic_rev_out && !blink_out && lines48_out == $past(c[1]))
    else $error("basic attribute wrong");
  irq_clr_a: assert property (wr && c == 4'h9 && !vblank_start_in |=> !vert_irq_out)
    else $error("interrupt not cleared");
  irq_set_a: assert property (vblank_start_in |=> vert_irq_out && fetch2_hold_out)
    else $error("interrupt or hold-off not raised");
  ignore_cmd_a: assert property (wr && c[3:2] == 2'h3 && !c[0] && !vblank_start_in |=>
    $stable({blink_out, reverse_field_out, vert_irq_out, basic_rev_out, lines48_out}))
    else $error("ignored command changed state");
  rom_addr_a: assert property (take && char_code_in != 8'hFF |=> rom_addr_out[11:4] == $past(char_code_in))
    else $error("ROM address code half wrong");
  term_seen_a: assert property (take && char_code_in == 8'hFF |-> ##[1:3] term_out)
    else $error("terminator not flagged");
  scan_range_a: assert property (!(scan_addr_out inside {[4'h9:4'hE]}) &&
    underline_scan_out == (scan_addr_out == 4'h7))
    else $error("scan address out of range");
  cover property (wr && c == 4'hD);
  cover property (take);
  cover property (vblank_start_in);
endmodule // vsc_check
bind video_scroll_char_control vsc_check #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_chk (
  .clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .pready_out, .paddr_in, .pwdata_in,
  .vblank_start_in, .vert_irq_out, .fetch2_hold_out, .blink_out, .reverse_field_out,
  .basic_rev_out, .lines48_out, .char_valid_in, .char_ready_out, .term_out,
  .underline_scan_out, .char_code_in, .rom_addr_out, .scan_addr_out);

// ### video_scroll_char_control_test.sv
// Self-checking bench for the scroll and character control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module video_scroll_char_control_test;
  reg clk_sys_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  reg [11:0] paddr_in = 0;
  reg [31:0] pwdata_in = 0;
  reg vert_reset_in = 0, vblank_start_in = 0, line_start_in = 0, line_loc0_in = 0;
  reg line_scroll_in = 0, scan_adv_in = 0, char_valid_in = 0, region_last_in = 0;
  wire line_done_out;
  reg [7:0] char_code_in = 0;
  wire [31:0] prdata_out;
  wire [11:0] rom_addr_out;
  wire [7:0] rom_data_in;
  wire [3:0] scan_addr_out;
  wire pready_out, pslverr_out, char_ready_out, term_out, dot_out, dot_valid_out;
  integer seed = 90644, bad_count = 0, cmp_count = 0, i, n, k;
  reg [12:0] st = 0;
  reg [31:0] rd, r;
  reg err;
  reg [9:0] got, exp;
  reg [7:0] d;
  always #2.5 clk_sys_in = ~clk_sys_in;
  video_scroll_char_control #(.HOLDOFF_CYCLES(20)) u_dut (
    .clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .vert_reset_in, .vblank_start_in, .line_start_in,
    .line_loc0_in, .line_scroll_in, .region_last_in, .scan_adv_in, .char_valid_in,
    .char_code_in, .rom_data_in, .char_ready_out, .rom_addr_out, .term_out,
    .col_overflow_out(), .dot_out, .dot_valid_out, .underline_scan_out(), .scan_addr_out,
    .line_done_out, .vert_irq_out(), .fetch2_hold_out(), .blink_out(),
    .reverse_field_out(), .basic_rev_out(), .lines48_out());
  char_rom_model u_rom (.addr_in(rom_addr_out), .data_out(rom_data_in));
  // Expected status image after one command
  function [12:0] upd(input [12:0] s, input [3:0] c);
    begin
      upd = s;
      case (c)
        4'h0, 4'h1, 4'h2, 4'h3: upd[1:0] = c[1:0];
        4'h4, 4'h5, 4'h6, 4'h7: upd[3:2] = c[1:0];
        4'h8: upd[8] = ~s[8];
        4'h9: upd[10] = 1'b0;
        4'hA: upd[9] = 1'b1;
        4'hB: upd[9] = 1'b0;
        4'hD, 4'hF: upd[12:11] = {c[1], 1'b1};
        default: ;
      endcase
      if (c == 4'hD || c == 4'hF) upd[8] = 1'b0;
    end
  endfunction
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task wait_hi(input integer sel);
    begin
      n = 0;
      do begin
        @(posedge clk_sys_in);
        n = n + 1;
      end while ((sel ? char_ready_out : pready_out) !== 1'b1 && n < 40);
      if (n >= 40) begin
        bad_count++;
        stop_test;
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] wd);
    begin
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge clk_sys_in);
      penable_in <= 1;
      wait_hi(0);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
      // Let an edge pass so a following call never re-drives psel in this step
      @(posedge clk_sys_in);
    end
  endtask
  task cmd(input [3:0] c);
    begin
      apb(1, 12'h00C, {28'h0, c});
      st = upd(st, c);
    end
  endtask
  task pulse(input integer sel);
    begin
      if (sel == 0) vert_reset_in <= 1;
      else vblank_start_in <= 1;
      @(posedge clk_sys_in);
      vert_reset_in <= 0;
      vblank_start_in <= 0;
      @(posedge clk_sys_in);
      if (sel == 0) st[7:4] = st[3:0];
      else st[10] = 1'b1;
    end
  endtask
  task chk_st;
    begin
      apb(0, 12'h010, 0);
      `CHK("status", st, rd[12:0])
    end
  endtask
  // Sends one code; nd dots expected, none for the terminator
  task chr(input [7:0] c, input integer nd, input rv);
    begin
      char_valid_in <= 1;
      char_code_in <= c;
      wait_hi(1);
      char_valid_in <= 0;
      got = 0;
      k = 0;
      for (n = 0; n < 60 && k < nd; n++) begin
        @(posedge clk_sys_in);
        if (dot_valid_out === 1'b1) begin
          got = {got[8:0], dot_out};
          k = k + 1;
        end
      end
      // Scan address is still F here, so the ROM model folds F0 into the code
      d = c[7:0] ^ 8'hF0;
      exp = (nd == 10) ? {d, d[0], d[0]} : {1'b0, d, d[0]};
      if (rv) exp = exp ^ ((nd == 10) ? 10'h3FF : 10'h1FF);
      if (nd == 0) begin
        for (n = 0; n < 8 && term_out !== 1'b1; n++) @(posedge clk_sys_in);
        `CHK("term", 1'b1, term_out)
      end else
        `CHK("dots", exp, got)
    end
  endtask
  task line(input l0, input rl);
    begin
      line_loc0_in <= l0;
      region_last_in <= rl;
      line_scroll_in <= 1;
      line_start_in <= 1;
      @(posedge clk_sys_in);
      line_start_in <= 0;
      repeat (2) @(posedge clk_sys_in);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1;
    @(posedge clk_sys_in);
    `CHK("ready", 1'b1, char_ready_out)
    `CHK("scan", 4'hF, scan_addr_out)
    chk_st;
    apb(0, 12'h00C, 0);
    `CHK("cmd read", 32'h0, rd)
    apb(0, 12'h040, 0);
    `CHK("unmapped", 1'b1, err)
    $display("reset test done");
    cmd(0);
    cmd(4);
    cmd(9);
    cmd(4'hB);
    cmd(4'hD);
    chk_st;
    for (i = 0; i < 16; i++) begin
      cmd(i[3:0]);
      chk_st;
    end
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      cmd(r[3:0]);
      if (r[4]) pulse(0);
      if (r[5]) pulse(1);
      chk_st;
    end
    $display("command test done");
    cmd(4'hB);
    r = $random(seed);
    chr(r[7:0] & 8'hFE, 10, 0);
    apb(1, 12'h014, 1);
    cmd(4'hA);
    chr(r[15:8] & 8'hFE, 9, 1);
    chr(8'hFF, 0, 0);
    $display("character test done");
    cmd(1);
    cmd(5);
    pulse(0);
    line(1, 0);
    `CHK("loc0 scan", 4'hF, scan_addr_out)
    line(0, 0);
    `CHK("first scan", 4'h4, scan_addr_out)
    repeat (4) begin
      scan_adv_in <= 1;
      @(posedge clk_sys_in);
      scan_adv_in <= 0;
      @(posedge clk_sys_in);
    end
    `CHK("last scan", 4'h8, scan_addr_out)
    line(0, 1);
    `CHK("inner scan", 4'hF, scan_addr_out)
    repeat (4) begin
      scan_adv_in <= 1;
      @(posedge clk_sys_in);
      scan_adv_in <= 0;
      @(posedge clk_sys_in);
    end
    `CHK("end scan", 4'h3, scan_addr_out)
    scan_adv_in <= 1;
    @(posedge clk_sys_in);
    scan_adv_in <= 0;
    @(posedge clk_sys_in);
    `CHK("line done", 1'b1, line_done_out)
    $display("scan test done");
    stop_test;
  end
endmodule // video_scroll_char_control_test
